// File: core/pbc_break_unit.sv
// two-channel program break comparator with apb register access
// How it works
// - fetch match executing sets flag, breaks first, except on one-word branches
// - condition field picks fetch, read, write, both
// - mask code bits 3..5 drop low bits
// - bit 0 enables request, flag always set
// - data break raised after instruction ends
// - stack and vector reads count as data
// - block move break waits for its end
// - dtc break waits count done or select
// - sleep entry skipped, break, then continue
// - to subactive: transition first, then break
// - to high speed: settle, transition, then break
// - standby or watch: no break, flag set
// - enabled breaks delay one-word branches one state
// - held stopped at reset, registers closed
// - one shared request, handler reads flags
// - flag clears by zero after reading one
// - accept only after dtc returns bus
// - unexecuted fetch after jumps never breaks
// - mask load blocks requests three states
// - conditional branch: break only if executed
// - 24-bit address, upper byte reserved zero
// - mask codes give 0,1,2,3,4,8,12,16 bits
// - channel b mirrors channel a
`timescale 1ns/1ps
`include "pbc_cfg.svh"
`default_nettype none
module pbc_break_unit (
	input  wire logic              pclk,
	input  wire logic              presetn,
	// apb register port
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// observed bus and cpu activity
	input  wire pbc_pkg::pbc_bus_t bus_mon,
	input  wire pbc_pkg::pbc_cpu_t cpu_evt,
	// deferral release events
	input  wire logic              block_move_active,
	input  wire logic              block_move_done,
	input  wire logic              dtc_count_done,
	input  wire logic              per_transfer_irq_select,
	input  wire logic              dtc_owns_bus,
	// power-down transitions
	input  wire logic              sleep_exec,
	input  wire pbc_pkg::pbc_sleep_t sleep_kind,
	input  wire logic [23:0]       sleep_next_pc,
	input  wire logic              mode_done,
	// requests back to the cpu
	output logic                   break_irq,
	output logic                   sleep_skip,
	output logic                   extra_state
);
	// register storage
	logic [23:0] break_addr_chan_a_r;     // channel a address
	logic [23:0] break_addr_chan_b_r;     // channel b address
	logic [7:0]  break_ctrl_chan_a_r;     // channel a control and flag
	logic [7:0]  break_ctrl_chan_b_r;     // channel b control and flag
	logic        stop_r;                  // module stop control
	logic [1:0]  read_one_r;              // flag seen as one by software
	logic [1:0]  pend_r;                  // matched, waiting for release
	logic [1:0]  armed_r;                 // released, may request
	logic [1:0]  blk_cnt_r;               // mask-load blocking counter
	logic [31:0] prdata_r;                // read data answer
	logic        pready_r;                // access-phase ready
	logic        pslverr_r;               // unmapped address answer
	logic        break_irq_r;             // shared request
	logic        sleep_skip_r;            // cancel sleep entry
	logic        extra_state_r;           // one-state stretch
	pbc_pkg::pbc_state_t st_r;            // deferral state
	pbc_pkg::pbc_state_t st_nxt;

	// bus decode
	wire setup_ph  = psel & ~penable;
	wire done_ph   = psel & penable & pready_r;
	wire wr_done   = done_ph & pwrite;
	wire rd_done   = done_ph & ~pwrite;
	wire sel_addr_a = (paddr == `PBC_OFS_ADDR_A);
	wire sel_addr_b = (paddr == `PBC_OFS_ADDR_B);
	wire sel_ctrl_a = (paddr == `PBC_OFS_CTRL_A);
	wire sel_ctrl_b = (paddr == `PBC_OFS_CTRL_B);
	wire sel_stop   = (paddr == `PBC_OFS_STOP);
	wire mapped     = sel_addr_a | sel_addr_b | sel_ctrl_a | sel_ctrl_b | sel_stop;
	wire open_regs  = ~stop_r;
	// the stop control itself stays reachable while halted, otherwise the
	// unit could never be started again

	// read mux; reserved bits read zero
	wire [31:0] rd_val =
		(sel_addr_a & open_regs) ? {8'h00, break_addr_chan_a_r} :
		(sel_addr_b & open_regs) ? {8'h00, break_addr_chan_b_r} :
		(sel_ctrl_a & open_regs) ? {24'h00_0000, break_ctrl_chan_a_r} :
		(sel_ctrl_b & open_regs) ? {24'h00_0000, break_ctrl_chan_b_r} :
		sel_stop ? {31'h0000_0000, stop_r} : 32'h0000_0000;

	// per-channel views
	// arrays let the channel loop below stay identical for both channels
	wire [23:0] ch_addr [2];
	wire [7:0]  ch_ctrl [2];
	assign ch_addr[0] = break_addr_chan_a_r;
	assign ch_addr[1] = break_addr_chan_b_r;
	assign ch_ctrl[0] = break_ctrl_chan_a_r;
	assign ch_ctrl[1] = break_ctrl_chan_b_r;

	// codes above four jump to 256-byte, 4k and 64k granules
	// mask code to low-bit mask
	function automatic logic [23:0] mask_of(input logic [2:0] code);
		case (code)
			3'h0: mask_of = 24'h00_0000;
			3'h1: mask_of = 24'h00_0001;
			3'h2: mask_of = 24'h00_0003;
			3'h3: mask_of = 24'h00_0007;
			3'h4: mask_of = 24'h00_000F;
			3'h5: mask_of = 24'h00_00FF;
			3'h6: mask_of = 24'h00_0FFF;
			3'h7: mask_of = 24'h00_FFFF;
			default: mask_of = 24'h00_0000;
		endcase
	endfunction

	// comparator per channel
	// fetch compares use the executing pc rather than bus fetches, so
	// prefetched words after a taken branch or a jump never raise a break
	logic [1:0] fetch_hit;     // executing instruction matches
	logic [1:0] sleep_hit;     // instruction after sleep matches
	logic [1:0] data_hit;      // data cycle matches
	logic [1:0] flag;          // match flags
	logic [1:0] irq_en;        // request enables
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ch
			wire [2:0]  mcode  = ch_ctrl[g][`PBC_BIT_MASK_HI:`PBC_BIT_MASK_LO];
			wire [1:0]  cond   = ch_ctrl[g][`PBC_BIT_COND_HI:`PBC_BIT_COND_LO];
			wire        any_m  = ch_ctrl[g][`PBC_BIT_MASTER];
			wire [23:0] keep   = ~mask_of(mcode);
			wire [23:0] want   = ch_addr[g] & keep;
			wire        is_fch = (cond == 2'h0);
			wire        rd_ok  = cond[0];
			wire        wr_ok  = cond[1];
			wire        mst_ok = ~bus_mon.transfer_controller | any_m;
			assign fetch_hit[g] = is_fch & cpu_evt.exec_start & ~cpu_evt.branch_1word
				& ((cpu_evt.exec_pc & keep) == want) & ~sleep_exec;
			assign sleep_hit[g] = is_fch & sleep_exec & ((sleep_next_pc & keep) == want);
			// stack and vector reads arrive as data reads
			assign data_hit[g]  = ~is_fch & bus_mon.valid & ~bus_mon.fetch & mst_ok
				& ((bus_mon.addr & keep) == want)
				& ((bus_mon.read & rd_ok) | (bus_mon.write & wr_ok));
			assign flag[g]   = ch_ctrl[g][`PBC_BIT_FLAG];
			assign irq_en[g] = ch_ctrl[g][`PBC_BIT_IRQ_EN];
		end
	endgenerate

	// match qualifiers while running
	// a stopped unit matches nothing new, but keeps its flags for software
	wire       run        = ~stop_r;
	wire [1:0] f_now      = run ? fetch_hit : 2'b00;
	wire [1:0] d_now      = run ? data_hit : 2'b00;
	wire [1:0] s_now      = run ? sleep_hit : 2'b00;
	wire       s_plain    = sleep_exec & (sleep_kind == pbc_pkg::PBC_SLP_SLEEP);
	wire       s_direct   = sleep_exec & ((sleep_kind == pbc_pkg::PBC_SLP_TO_SUB)
		| (sleep_kind == pbc_pkg::PBC_SLP_TO_HIGH));
	wire       s_standby  = sleep_exec & (sleep_kind == pbc_pkg::PBC_SLP_STANDBY);
	wire       via_dtc    = bus_mon.transfer_controller;
	wire       in_block   = block_move_active;
	// events released at once
	wire [1:0] arm_now    = f_now | (s_plain ? s_now : 2'b00);
	// events deferred to a later moment
	wire [1:0] defer_now  = d_now | (s_direct ? s_now : 2'b00);

	// release conditions per wait kind
	// a data match made by the transfer controller waits for its count or the per-transfer select
	// data break after instruction end
	wire rel_end  = cpu_evt.insn_end & ~in_block;
	wire rel_blk  = block_move_done;
	// dtc count done or per-transfer select
	wire rel_xfer = dtc_count_done | per_transfer_irq_select;
	wire rel_mode = mode_done;

	// deferral state machine
	// only one wait is tracked: a second deferred match joins the one in flight
	// and is released with it, which may bring its request a little early
	// a block move takes precedence over the plain end of instruction, as
	// one move instruction spans many transfers
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			pbc_pkg::PBC_IDLE: begin
				if (|defer_now) begin
					if (s_direct)
						st_nxt = pbc_pkg::PBC_WAIT_MODE;
					else if (via_dtc)
						st_nxt = pbc_pkg::PBC_WAIT_XFER;
					else
						st_nxt = pbc_pkg::PBC_WAIT_END;
				end
			end
			pbc_pkg::PBC_WAIT_END: begin
				if (in_block ? rel_blk : rel_end)
					st_nxt = pbc_pkg::PBC_IDLE;
			end
			pbc_pkg::PBC_WAIT_XFER: begin
				if (rel_xfer)
					st_nxt = pbc_pkg::PBC_IDLE;
			end
			pbc_pkg::PBC_WAIT_MODE: begin
				if (rel_mode)
					st_nxt = pbc_pkg::PBC_IDLE;
			end
			default: st_nxt = pbc_pkg::PBC_IDLE;
		endcase
	end
	wire release_now = (st_r != pbc_pkg::PBC_IDLE) && (st_nxt == pbc_pkg::PBC_IDLE);
	wire [1:0] rel_flag   = release_now ? pend_r : 2'b00;
	// sleep matches bound to a transition wait like data matches
	wire [1:0] s_flag_now = s_direct ? 2'b00 : s_now;
	// events that set flags this cycle
	wire [1:0] set_flag   = f_now | s_flag_now | rel_flag;

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			st_r <= pbc_pkg::PBC_IDLE;
		else
			st_r <= st_nxt;
	end

	// software clear of flags after reading one
	// zero written after one was read
	wire [1:0] wr_ctrl    = {wr_done & sel_ctrl_b & open_regs, wr_done & sel_ctrl_a & open_regs};
	wire [1:0] clr_flag   = wr_ctrl & read_one_r & {2{~pwdata[`PBC_BIT_FLAG]}};
	wire [1:0] rd_ctrl    = {rd_done & sel_ctrl_b & open_regs, rd_done & sel_ctrl_a & open_regs};

	// flag next values, set wins over clear
	wire [1:0] flag_nxt   = set_flag | (flag & ~clr_flag);

	// register writes and flag updates
	// the flag bit is never written from the bus: software can only clear it,
	// and only through the read-one handshake
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			break_addr_chan_a_r <= `PBC_RST_ADDR;
			break_addr_chan_b_r <= `PBC_RST_ADDR;
			break_ctrl_chan_a_r <= `PBC_RST_CTRL;
			break_ctrl_chan_b_r <= `PBC_RST_CTRL;
			stop_r              <= `PBC_RST_STOP;
		end else begin
			if (wr_done & sel_addr_a & open_regs)
				break_addr_chan_a_r <= pwdata[23:0];
			if (wr_done & sel_addr_b & open_regs)
				break_addr_chan_b_r <= pwdata[23:0];
			if (wr_ctrl[0])
				break_ctrl_chan_a_r[6:0] <= pwdata[6:0];
			if (wr_ctrl[1])
				break_ctrl_chan_b_r[6:0] <= pwdata[6:0];
			// flag also set on standby entry
			break_ctrl_chan_a_r[`PBC_BIT_FLAG] <= flag_nxt[0];
			break_ctrl_chan_b_r[`PBC_BIT_FLAG] <= flag_nxt[1];
			if (wr_done & sel_stop)
				stop_r <= pwdata[0];
		end
	end

	// read-one tracking, dropped once the flag is cleared
	// a flag of zero in the read's access cycle does not arm the clear, so a flag set after that cycle
	// is never lost to a stale clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			read_one_r <= 2'b00;
		else
			read_one_r <= (read_one_r | (rd_ctrl & flag)) & flag_nxt;
	end

	// pending and armed channel sets
	// a channel stays armed while its flag stands; clearing the flag disarms it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_r  <= 2'b00;
			armed_r <= 2'b00;
		end else begin
			pend_r  <= release_now ? defer_now : (pend_r | defer_now);
			armed_r <= (armed_r | arm_now | (release_now ? pend_r : 2'b00)) & flag_nxt;
		end
	end

	// the counter starts on the load itself; with the request register behind
	// it, requests stay low for three sampled cycles
	// mask load blocks requests for a while
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			blk_cnt_r <= 2'h0;
		else if (cpu_evt.imask_load)
			blk_cnt_r <= 2'(`PBC_MASKBLK_STATES);
		else if (blk_cnt_r != 2'h0)
			blk_cnt_r <= blk_cnt_r - 2'h1;
	end

	// the request is a level: it stays up while a flag is armed and enabled,
	// so a flag left set asks again once the handler returns
	// one shared request for both channels
	// held off while the dtc owns the bus
	wire irq_nxt = (|(armed_r & flag & irq_en)) & ~dtc_owns_bus & (blk_cnt_r == 2'h0);

	// the stretch follows the enable bits and the stop control, not whether a break is pending
	// one-word branches stretched while enabled
	wire extra_nxt = cpu_evt.branch_1word & (|irq_en) & run;

	// cancel sleep entry when a break stands
	wire skip_nxt = s_plain & (|s_now);

	// request and cpu-side strobes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			break_irq_r   <= 1'b0;
			extra_state_r <= 1'b0;
			sleep_skip_r  <= 1'b0;
		end else begin
			break_irq_r   <= irq_nxt;
			extra_state_r <= extra_nxt;
			sleep_skip_r  <= skip_nxt;
		end
	end

	// apb answer: registered in setup, ready in first access cycle
	// every access completes with no wait state, so a master never stalls here;
	// read data are captured at setup, which keeps prdata off the long mux path
	// but shows software the flag one cycle before the access cycle that arms the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r  <= 32'h0000_0000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else if (setup_ph) begin
			prdata_r  <= pwrite ? 32'h0000_0000 : rd_val;
			pready_r  <= 1'b1;
			pslverr_r <= ~mapped;
		end else begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end
	end

	// outputs straight from flip-flops
	// no output is decoded combinationally, so the cpu sees clean levels
	assign prdata      = prdata_r;
	assign pready      = pready_r;
	assign pslverr     = pslverr_r;
	assign break_irq   = break_irq_r;
	assign sleep_skip  = sleep_skip_r;
	assign extra_state = extra_state_r;
endmodule // pbc_break_unit
`default_nettype wire

// File: core/pbc_cfg.svh
// register offsets, field positions, reset values and timing counts of the break unit
`ifndef PBC_CFG_SVH
`define PBC_CFG_SVH
`define PBC_OFS_ADDR_A      12'h000
`define PBC_OFS_ADDR_B      12'h004
`define PBC_OFS_CTRL_A      12'h008
`define PBC_OFS_CTRL_B      12'h00C
`define PBC_OFS_STOP        12'h010
`define PBC_BIT_FLAG        7
`define PBC_BIT_MASTER      6
`define PBC_BIT_MASK_HI     5
`define PBC_BIT_MASK_LO     3
`define PBC_BIT_COND_HI     2
`define PBC_BIT_COND_LO     1
`define PBC_BIT_IRQ_EN      0
`define PBC_RST_ADDR        24'h00_0000
`define PBC_RST_CTRL        8'h00
`define PBC_RST_STOP        1'b1
`define PBC_MASKBLK_STATES  3
`define PBC_IVALID_STATES   2
`endif

// File: core/pbc_pkg.sv
// types shared by the break unit and its bench
`default_nettype none
package pbc_pkg;
	// one observed cycle of the on-chip bus
	typedef struct packed {
		logic        valid;
		logic [23:0] addr;
		logic        fetch;
		logic        read;
		logic        write;
		logic        transfer_controller;
	} pbc_bus_t;
	// one instruction-flow event from the cpu
	typedef struct packed {
		logic        exec_start;
		logic [23:0] exec_pc;
		logic        insn_end;
		logic        branch_1word;
		logic        imask_load;
	} pbc_cpu_t;
	// power-down transition requested by the sleep instruction
	typedef enum logic [2:0] {
		PBC_SLP_SLEEP   = 3'h0,
		PBC_SLP_TO_SUB  = 3'h1,
		PBC_SLP_TO_HIGH = 3'h2,
		PBC_SLP_STANDBY = 3'h3
	} pbc_sleep_t;
	// what a pending break is waiting for
	typedef enum logic [1:0] {
		PBC_IDLE      = 2'h0,
		PBC_WAIT_END  = 2'h1,
		PBC_WAIT_XFER = 2'h3,
		PBC_WAIT_MODE = 2'h2
	} pbc_state_t;
endpackage
`default_nettype wire

// File: test/pbc_break_unit_chk.sv
// port-level assertion checker for the break unit
`timescale 1ns/1ps
`default_nettype none
module pbc_break_unit_chk (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [11:0]       paddr,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire pbc_pkg::pbc_cpu_t cpu_evt,
	input wire logic              dtc_owns_bus,
	input wire logic              break_irq,
	input wire logic              sleep_skip,
	input wire logic              extra_state
);
	// one clock domain, one reset
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_RDY_NEXT: assert property (psel && !penable |=> pready)
		else $error("no zero-wait answer");
	AST_RDY_ONCE: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	AST_ERR_MAP: assert property (psel && !penable && paddr > 12'h010 |=> pslverr && pready)
		else $error("unmapped access not refused");
	AST_ADDR_TOP: assert property (pready && !pwrite && paddr < 12'h008 |-> prdata[31:24] == 8'h00)
		else $error("address upper byte not zero");
	AST_CTRL_TOP: assert property (pready && !pwrite && (paddr == 12'h008 || paddr == 12'h00C)
		|-> prdata[31:8] == 24'h000000)
		else $error("control upper bits not zero");
	AST_IMASK: assert property (cpu_evt.imask_load |=> ##1 !break_irq [*2])
		else $error("request during mask load block");
	AST_DTC_HOLD: assert property (dtc_owns_bus [*2] |-> !break_irq)
		else $error("request while transfer owns bus");
	AST_SKIP_PULSE: assert property (sleep_skip |=> !sleep_skip)
		else $error("sleep skip not a pulse");
	AST_EXTRA: assert property (extra_state |-> $past(cpu_evt.branch_1word) && !$past(extra_state))
		else $error("extra state without branch");
	// main scenarios reached
	cover property (break_irq);
	cover property (sleep_skip);
	cover property (pslverr);
	cover property (extra_state);
endmodule // pbc_break_unit_chk
bind pbc_break_unit pbc_break_unit_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .cpu_evt(cpu_evt), .dtc_owns_bus(dtc_owns_bus), .break_irq(break_irq),
	.sleep_skip(sleep_skip), .extra_state(extra_state));
`default_nettype wire

// File: test/pbc_break_unit_tb.sv
// self-checking bench for the break unit
`timescale 1ns/1ps
`include "pbc_cfg.svh"
`default_nettype none
module pbc_break_unit_tb;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, q, c;
	logic pready, pslverr, break_irq, sleep_skip, extra_state, e;
	logic bm_act = 1'h0, bm_done = 1'h0, cnt_done = 1'h0, sel_done = 1'h0;
	logic xfer_bus = 1'h0, slp = 1'h0, mdone = 1'h0;
	logic [23:0] npc = 24'h0;
	pbc_pkg::pbc_sleep_t kind = pbc_pkg::PBC_SLP_SLEEP;
	pbc_pkg::pbc_bus_t bus_mon;
	pbc_pkg::pbc_cpu_t cpu_evt;
	int miscompares = 0, tests_run = 0, cyc = 0, n;
	int mw[8] = '{0, 1, 2, 3, 4, 8, 12, 16};
	pbc_break_unit DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bus_mon(bus_mon), .cpu_evt(cpu_evt), .block_move_active(bm_act),
		.block_move_done(bm_done), .dtc_count_done(cnt_done), .per_transfer_irq_select(sel_done),
		.dtc_owns_bus(xfer_bus), .sleep_exec(slp), .sleep_kind(kind), .sleep_next_pc(npc),
		.mode_done(mdone), .break_irq(break_irq), .sleep_skip(sleep_skip),
		.extra_state(extra_state));
	pbc_cpu_model u_cpu (.pclk(pclk), .bus_mon(bus_mon), .cpu_evt(cpu_evt));
	always #5 pclk = ~pclk;
	// cycle ceiling cuts a hang short
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			results();
		end
	end
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		tests_run++;
		if (s !== x) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic w(input int k);
		repeat (k) @(posedge pclk);
	endtask
	// one apb transfer held until pready
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rq, output logic re);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		rq = prdata;
		re = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// read the flag, then rewrite control with it cleared
	task automatic flag(input logic [11:0] a, input logic x, input logic [31:0] cv);
		apb(1'h0, a, 32'h0, q, e);
		chk("flag", q[7], x);
		apb(1'h1, a, cv, q, e);
	endtask
	task automatic results();
		$display("tests_run %0d miscompares %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, `PBC_OFS_STOP, 32'h0, q, e);
		chk("stop", q[0], 1'h1);
		apb(1'h1, `PBC_OFS_ADDR_A, 32'h55, q, e);
		apb(1'h0, `PBC_OFS_ADDR_A, 32'h0, q, e);
		chk("addr stopped", q, 32'h0);
		apb(1'h1, `PBC_OFS_STOP, 32'h0, q, e);
		apb(1'h1, `PBC_OFS_ADDR_A, 32'hFF12_3456, q, e);
		apb(1'h0, `PBC_OFS_ADDR_A, 32'h0, q, e);
		chk("addr a", q, 32'h0012_3456);
		apb(1'h0, 12'h014, 32'h0, q, e);
		chk("unmapped", e, 1'h1);
		// mask code sweep: edge bit inside and outside the mask
		for (int i = 0; i < 8; i++) begin
			c = {26'h0, i[2:0], 3'h0};
			apb(1'h1, `PBC_OFS_CTRL_A, c, q, e);
			if (mw[i] > 0) begin
				u_cpu.fetch(24'h123456 ^ (24'h1 << (mw[i] - 1)), 1'h0);
				w(2);
				chk("irq off", break_irq, 1'h0);
				flag(`PBC_OFS_CTRL_A, 1'h1, c);
			end
			u_cpu.fetch(24'h123456 ^ (24'h1 << mw[i]), 1'h0);
			flag(`PBC_OFS_CTRL_A, 1'h0, c);
		end
		// channel b fetch break on the shared request
		apb(1'h1, `PBC_OFS_ADDR_B, 32'h00AB_CDE0, q, e);
		apb(1'h1, `PBC_OFS_CTRL_B, 32'h01, q, e);
		u_cpu.fetch(24'hABCDE0, 1'h0);
		w(3);
		chk("irq fetch", break_irq, 1'h1);
		flag(`PBC_OFS_CTRL_A, 1'h0, c);
		chk("irq held", break_irq, 1'h1);
		flag(`PBC_OFS_CTRL_B, 1'h1, 32'h01);
		w(3);
		chk("irq cleared", break_irq, 1'h0);
		// every condition code against read and write cycles
		for (int k = 0; k < 4; k++) begin
			c = {29'h0, k[1:0], 1'h1};
			apb(1'h1, `PBC_OFS_CTRL_A, c, q, e);
			for (int r = 0; r < 2; r++) begin
				u_cpu.acc(24'h123456, r == 0, r == 1, 1'h0);
				w(3);
				chk("irq early", break_irq, 1'h0);
				apb(1'h0, `PBC_OFS_CTRL_A, 32'h0, q, e);
				chk("flag early", q[7], 1'h0);
				u_cpu.evt(1'h1, 1'h0);
				w(3);
				chk("irq data", break_irq, k[r]);
				flag(`PBC_OFS_CTRL_A, k[r], c);
				w(3);
			end
		end
		// transfer cycles ignored when cpu only
		apb(1'h1, `PBC_OFS_CTRL_A, 32'h03, q, e);
		u_cpu.acc(24'h123456, 1'h1, 1'h0, 1'h1);
		u_cpu.evt(1'h1, 1'h0);
		flag(`PBC_OFS_CTRL_A, 1'h0, 32'h03);
		apb(1'h1, `PBC_OFS_CTRL_A, 32'h43, q, e);
		// transfer break held for count or select, then for the bus
		for (int t = 0; t < 2; t++) begin
			xfer_bus <= 1'h1;
			u_cpu.acc(24'h123456, 1'h1, 1'h0, 1'h1);
			u_cpu.evt(1'h1, 1'h0);
			w(3);
			chk("irq pre count", break_irq, 1'h0);
			cnt_done <= (t == 0);
			sel_done <= (t == 1);
			w(1);
			cnt_done <= 1'h0;
			sel_done <= 1'h0;
			w(3);
			chk("irq bus held", break_irq, 1'h0);
			xfer_bus <= 1'h0;
			w(3);
			chk("irq bus back", break_irq, 1'h1);
			flag(`PBC_OFS_CTRL_A, 1'h1, 32'h43);
			w(3);
		end
		// block move defers the break to its end
		bm_act <= 1'h1;
		u_cpu.acc(24'h123456, 1'h1, 1'h0, 1'h0);
		u_cpu.evt(1'h1, 1'h0);
		w(3);
		chk("irq in move", break_irq, 1'h0);
		bm_done <= 1'h1;
		w(1);
		bm_done <= 1'h0;
		bm_act <= 1'h0;
		w(3);
		chk("irq move end", break_irq, 1'h1);
		flag(`PBC_OFS_CTRL_A, 1'h1, 32'h01);
		// each power-down kind with a fetch break after the sleep
		for (int s = 0; s < 4; s++) begin
			w(3);
			slp <= 1'h1;
			kind <= pbc_pkg::pbc_sleep_t'(s[2:0]);
			npc <= 24'h123456;
			w(1);
			slp <= 1'h0;
			npc <= 24'hEDCBA9;
			n = 0;
			repeat (4) begin
				@(posedge pclk);
				n += sleep_skip;
			end
			chk("skip", n, s == 0);
			chk("irq sleep", break_irq, s == 0);
			mdone <= 1'h1;
			w(1);
			mdone <= 1'h0;
			w(3);
			chk("irq mode", break_irq, s < 3);
			flag(`PBC_OFS_CTRL_A, 1'h1, 32'h01);
		end
		// one-word branch stretched while a break is enabled
		u_cpu.fetch(24'h000100, 1'h1);
		n = 0;
		repeat (3) begin
			@(posedge pclk);
			n += extra_state;
		end
		chk("extra", n, 1);
		// mask load holds back a standing fetch break
		u_cpu.fetch(24'h123456, 1'h0);
		u_cpu.evt(1'h0, 1'h1);
		w(2);
		chk("irq masked", break_irq, 1'h0);
		w(3);
		chk("irq unmasked", break_irq, 1'h1);
		results();
	end
endmodule // pbc_break_unit_tb
`default_nettype wire

// File: test/pbc_cpu_model.sv
// behavioural cpu and bus activity seen by the break unit
`timescale 1ns/1ps
`default_nettype none
module pbc_cpu_model (
	input  wire logic              pclk,
	output var pbc_pkg::pbc_bus_t  bus_mon,
	output var pbc_pkg::pbc_cpu_t  cpu_evt
);
	// quiet bus at time zero
	initial begin
		bus_mon = '0;
		cpu_evt = '0;
	end
	// first byte address
	// start the instruction at pc, br marks a one-word branch
	task automatic fetch(input logic [23:0] pc, input logic br);
		@(posedge pclk);
		cpu_evt.exec_start <= 1'h1;
		cpu_evt.exec_pc <= pc;
		cpu_evt.branch_1word <= br;
		@(posedge pclk);
		cpu_evt.exec_start <= 1'h0;
		cpu_evt.branch_1word <= 1'h0;
		// released pc shows its inverse
		cpu_evt.exec_pc <= ~pc;
	endtask
	// one data bus cycle, then release with inverted lines
	task automatic acc(input logic [23:0] a, input logic r, input logic w, input logic d);
		@(posedge pclk);
		bus_mon <= {1'h1, a, 1'h0, r, w, d};
		@(posedge pclk);
		bus_mon <= {1'h0, ~a, 1'h0, ~r, ~w, ~d};
	endtask
	// end of instruction or mask load pulse
	task automatic evt(input logic e, input logic m);
		@(posedge pclk);
		cpu_evt.insn_end <= e;
		cpu_evt.imask_load <= m;
		@(posedge pclk);
		cpu_evt.insn_end <= 1'h0;
		cpu_evt.imask_load <= 1'h0;
	endtask
endmodule // pbc_cpu_model
`default_nettype wire
